// >>> src/sgc_map.svh
// register offsets, field positions, reset values and ratio counts of the switch global control
`ifndef SGC_MAP_SVH
`define SGC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SGC_ADDR_CTRL1      8'h03
`define SGC_ADDR_PRIO       8'h04
`define SGC_ADDR_PORT       8'h06
`define SGC_ADDR_STATUS     8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SGC_BIT_BACKOFF     0
`define SGC_BIT_SNIFF       0
`define SGC_FLD_PRIO_LO     2
`define SGC_FLD_PRIO_HI     3
`define SGC_BIT_BP          7
`define SGC_BIT_HALF        6
`define SGC_BIT_FC          5
`define SGC_BIT_SPD10       4
`define SGC_BIT_NULLVID     3
`define SGC_BIT_LOADED      7

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SGC_PRIO_RST        8'h00
`define SGC_BP_RST          1'h0
`define SGC_NULLVID_RST     1'h0
`define SGC_RATIO_10        4'hA
`define SGC_RATIO_5         4'h5
`define SGC_RATIO_2         4'h2

`endif

// >>> src/sgc_pkg.sv
// types shared by the switch global control block
package sgc_pkg;

    typedef enum logic [1:0]
    {
        SGC_PRIO_STRICT,
        SGC_PRIO_R10,
        SGC_PRIO_R5,
        SGC_PRIO_R2
    } sgc_prio_e;

    // switch mii port settings, msb first as they sit in the register
    typedef struct packed
    {
        logic bp_en;
        logic half_duplex;
        logic fc_en;
        logic speed_10;
        logic null_vid_en;
    } sgc_smii_cfg_s;

    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sgc_rb_req_s;

endpackage

// >>> src/sgc_egress_sched.sv
// high/low priority egress slot scheduler
`timescale 1ns/1ns
`include "sgc_map.svh"

module sgc_egress_sched
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire sgc_pkg::sgc_prio_e scheme,
    input  wire logic              slot,
    input  wire logic              hi_pend,
    input  wire logic              lo_pend,
    output logic                   take_hi_q,
    output logic                   take_lo_q,
    output logic [3:0]             hi_run_q
);

    // ----------------------------------------------------------------
    // pick
    // ----------------------------------------------------------------
    wire logic [3:0] ratio_lim;
    wire logic       ratio_hit;
    wire logic       pick_lo;
    wire logic       pick_hi;
    wire logic [3:0] hi_run_d;

    assign ratio_lim = (scheme == sgc_pkg::SGC_PRIO_R10) ? `SGC_RATIO_10 :
                       (scheme == sgc_pkg::SGC_PRIO_R5)  ? `SGC_RATIO_5  :
                       `SGC_RATIO_2;
    // strict never lets low pass while high waits
    assign ratio_hit = (scheme != sgc_pkg::SGC_PRIO_STRICT)
                       && (hi_run_q >= ratio_lim);
    assign pick_lo   = lo_pend && (!hi_pend || ratio_hit);
    assign pick_hi   = hi_pend && !pick_lo;
    // run counts high grants only while low is starved
    assign hi_run_d  = (slot && pick_lo) ? 4'h0 :
                       (slot && pick_hi) ? (lo_pend ? hi_run_q + 4'h1 : 4'h0) :
                       hi_run_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            take_hi_q <= 1'b0;
            take_lo_q <= 1'b0;
            hi_run_q  <= 4'h0;
        end
        else if (ce)
        begin
            take_hi_q <= slot && pick_hi;
            take_lo_q <= slot && pick_lo;
            hi_run_q  <= hi_run_d;
        end
    end

endmodule

// >>> src/sgc_global_ctrl.sv
// global control registers of the five-port switch and the logic they steer
//
// Overview of operation
// - aggressive back-off bit enables faster non-standard half-duplex back-off; strap default off
// - two-bit scheme: 00 strict, 01 ten-to-one, 10 five-to-one, 11 two-to-one
// - scheme resets to strict: all queued high packets go before low
// - sniff mode 1 mirrors only when source and destination both match
// - sniff mode 0, the reset value, mirrors when source or destination matches
// - back pressure bit enables half-duplex back pressure on switch mii; reset off
// - duplex bit: 1 half duplex, 0 full duplex on switch mii
// - duplex bit resets from its strap pin; pull-down default is full duplex
// - flow control bit enables full-duplex flow control on switch mii
// - flow control bit resets from its strap pin; default disabled
// - speed bit: 1 is 10 Mbps, 0 is 100 Mbps; strap default 100
// - null vid bit replaces a zero vlan id by the port default id
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "sgc_map.svh"

module sgc_global_ctrl
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // register port
    input  wire sgc_pkg::sgc_rb_req_s  rb_req,
    output logic [7:0]                 rd_data_q,
    // strap pins
    input  wire logic                  backoff_strap_pin,
    input  wire logic                  duplex_strap_pin,
    input  wire logic                  flow_ctrl_strap_pin,
    input  wire logic                  speed_strap_pin,
    // settings to the mac and port logic
    output logic                       backoff_aggr_q,
    output sgc_pkg::sgc_smii_cfg_s     smii_cfg_q,
    // switch mii congestion handling
    input  wire logic                  smii_congested,
    output logic                       smii_jam_q,
    output logic                       smii_pause_q,
    // sniffer match
    input  wire logic                  pkt_valid,
    input  wire logic                  pkt_src_match,
    input  wire logic                  pkt_dst_match,
    output logic                       mirror_valid_q,
    output logic                       mirror_q,
    // vlan id replacement
    input  wire logic                  vid_valid,
    input  wire logic [11:0]           vid_in,
    input  wire logic [11:0]           port_vid,
    output logic                       vid_valid_q,
    output logic [11:0]                vid_out_q,
    // egress scheduler
    input  wire logic                  egr_slot,
    input  wire logic                  egr_hi_pend,
    input  wire logic                  egr_lo_pend,
    output logic                       egr_take_hi_q,
    output logic                       egr_take_lo_q
);

    // ----------------------------------------------------------------
    // strap synchronisers
    // ----------------------------------------------------------------
    // no reset on these, so the pins are already settled when reset lifts
    logic [3:0] strap_s1_q;
    logic [3:0] strap_s2_q;
    wire  logic [3:0] strap_pins;

    assign strap_pins = {backoff_strap_pin, duplex_strap_pin,
                         flow_ctrl_strap_pin, speed_strap_pin};

    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            strap_s1_q <= strap_pins;
            strap_s2_q <= strap_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire logic wr_ctrl1;
    wire logic wr_prio;
    wire logic wr_port;
    wire logic strap_load;

    assign wr_ctrl1   = rb_req.wr && (rb_req.addr == `SGC_ADDR_CTRL1);
    assign wr_prio    = rb_req.wr && (rb_req.addr == `SGC_ADDR_PRIO);
    assign wr_port    = rb_req.wr && (rb_req.addr == `SGC_ADDR_PORT);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic       loaded_q;
    logic [7:0] prio_q;
    logic [3:0] strap_seen_q;

    // one-shot load on the first enabled edge after release
    assign strap_load = !loaded_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            loaded_q     <= 1'b0;
            strap_seen_q <= 4'h0;
        end
        else if (ce && strap_load)
        begin
            loaded_q     <= 1'b1;
            strap_seen_q <= strap_s2_q;
        end
    end

    // the async reset gives the pull-down level; the strap load follows at once
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            backoff_aggr_q <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_ctrl1)
            begin
                backoff_aggr_q <= rb_req.wdata[`SGC_BIT_BACKOFF];
            end
            else if (strap_load)
            begin
                backoff_aggr_q <= strap_s2_q[3];
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prio_q <= `SGC_PRIO_RST;
        end
        else if (ce && wr_prio)
        begin
            prio_q <= rb_req.wdata;
        end
    end

    // a write in the load cycle wins, so software always has the last word
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            smii_cfg_q.bp_en       <= `SGC_BP_RST;
            smii_cfg_q.half_duplex <= 1'b0;
            smii_cfg_q.fc_en       <= 1'b0;
            smii_cfg_q.speed_10    <= 1'b0;
            smii_cfg_q.null_vid_en <= `SGC_NULLVID_RST;
        end
        else if (ce)
        begin
            if (wr_port)
            begin
                smii_cfg_q.bp_en       <= rb_req.wdata[`SGC_BIT_BP];
                smii_cfg_q.half_duplex <= rb_req.wdata[`SGC_BIT_HALF];
                smii_cfg_q.fc_en       <= rb_req.wdata[`SGC_BIT_FC];
                smii_cfg_q.speed_10    <= rb_req.wdata[`SGC_BIT_SPD10];
                smii_cfg_q.null_vid_en <= rb_req.wdata[`SGC_BIT_NULLVID];
            end
            else if (strap_load)
            begin
                smii_cfg_q.half_duplex <= strap_s2_q[2];
                smii_cfg_q.fc_en       <= strap_s2_q[1];
                smii_cfg_q.speed_10    <= strap_s2_q[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    wire logic [7:0] rd_ctrl1;
    wire logic [7:0] rd_port;
    wire logic [7:0] rd_status;
    wire logic [7:0] rd_mux;

    assign rd_ctrl1  = {7'h00, backoff_aggr_q};
    // low three bits belong to other logic and read as zero here
    assign rd_port   = {smii_cfg_q.bp_en, smii_cfg_q.half_duplex, smii_cfg_q.fc_en,
                        smii_cfg_q.speed_10, smii_cfg_q.null_vid_en, 3'h0};
    assign rd_status = {loaded_q, 3'h0, strap_seen_q};
    assign rd_mux    = (rb_req.addr == `SGC_ADDR_CTRL1)  ? rd_ctrl1  :
                       (rb_req.addr == `SGC_ADDR_PRIO)   ? prio_q    :
                       (rb_req.addr == `SGC_ADDR_PORT)   ? rd_port   :
                       (rb_req.addr == `SGC_ADDR_STATUS) ? rd_status :
                       8'h00;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_q <= 8'h00;
        end
        else if (ce)
        begin
            rd_data_q <= rb_req.rd ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // switch mii congestion
    // ----------------------------------------------------------------
    // jam only makes sense half duplex, pause frames only full duplex
    wire logic jam_d;
    wire logic pause_d;

    assign jam_d   = smii_cfg_q.bp_en && smii_cfg_q.half_duplex
                     && smii_congested;
    assign pause_d = smii_cfg_q.fc_en && !smii_cfg_q.half_duplex
                     && smii_congested;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            smii_jam_q   <= 1'b0;
            smii_pause_q <= 1'b0;
        end
        else if (ce)
        begin
            smii_jam_q   <= jam_d;
            smii_pause_q <= pause_d;
        end
    end

    // ----------------------------------------------------------------
    // sniffer match
    // ----------------------------------------------------------------
    wire logic sniff_and;
    wire logic mirror_d;

    assign sniff_and = prio_q[`SGC_BIT_SNIFF];
    assign mirror_d  = sniff_and ? (pkt_src_match && pkt_dst_match)
                                 : (pkt_src_match || pkt_dst_match);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mirror_valid_q <= 1'b0;
            mirror_q       <= 1'b0;
        end
        else if (ce)
        begin
            mirror_valid_q <= pkt_valid;
            mirror_q       <= pkt_valid && mirror_d;
        end
    end

    // ----------------------------------------------------------------
    // null vid replacement
    // ----------------------------------------------------------------
    wire logic        vid_null;
    wire logic [11:0] vid_d;

    assign vid_null = (vid_in == 12'h000);
    assign vid_d    = (smii_cfg_q.null_vid_en && vid_null) ? port_vid
                                                           : vid_in;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            vid_valid_q <= 1'b0;
            vid_out_q   <= 12'h000;
        end
        else if (ce)
        begin
            vid_valid_q <= vid_valid;
            vid_out_q   <= vid_valid ? vid_d : 12'h000;
        end
    end

    // ----------------------------------------------------------------
    // egress scheduling
    // ----------------------------------------------------------------
    wire sgc_pkg::sgc_prio_e scheme;

    assign scheme = sgc_pkg::sgc_prio_e'(prio_q[`SGC_FLD_PRIO_HI:`SGC_FLD_PRIO_LO]);

    sgc_egress_sched u_sched
    (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .scheme    (scheme),
        .slot      (egr_slot),
        .hi_pend   (egr_hi_pend),
        .lo_pend   (egr_lo_pend),
        .take_hi_q (egr_take_hi_q),
        .take_lo_q (egr_take_lo_q),
        .hi_run_q  ()
    );

endmodule

// >>> sim/sgc_global_ctrl_checker.sv
// concurrent checks on the ports of the switch global control block
`timescale 1ns/1ns
`include "sgc_map.svh"

module sgc_global_ctrl_checker
(
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   ce,
    input wire sgc_pkg::sgc_rb_req_s   rb_req,
    input wire logic [7:0]             rd_data_q,
    input wire sgc_pkg::sgc_smii_cfg_s smii_cfg_q,
    input wire logic                   smii_congested,
    input wire logic                   smii_jam_q,
    input wire logic                   smii_pause_q,
    input wire logic                   pkt_valid,
    input wire logic                   pkt_src_match,
    input wire logic                   pkt_dst_match,
    input wire logic                   mirror_q,
    input wire logic                   vid_valid,
    input wire logic [11:0]            vid_in,
    input wire logic [11:0]            port_vid,
    input wire logic [11:0]            vid_out_q,
    input wire logic                   egr_slot,
    input wire logic                   egr_hi_pend,
    input wire logic                   egr_take_hi_q,
    input wire logic                   egr_take_lo_q
);
    logic [7:0]  prio_q;

    // ----------------------------------------------------------------
    // shadow of the priority register
    // ----------------------------------------------------------------
    // sniff mode and scheme are not visible at the ports otherwise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prio_q <= 8'h00;
        else if (ce && rb_req.wr && rb_req.addr == `SGC_ADDR_PRIO)
            prio_q <= rb_req.wdata;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_JAM: assert property (smii_jam_q == ($past(smii_cfg_q.bp_en)
        && $past(smii_cfg_q.half_duplex) && $past(smii_congested))) else $error("jam wrong");
    AST_PAUSE: assert property (smii_pause_q == ($past(smii_cfg_q.fc_en)
        && !$past(smii_cfg_q.half_duplex) && $past(smii_congested))) else $error("pause wrong");
    AST_MIRROR: assert property ($past(pkt_valid) |-> mirror_q == ($past(prio_q[0])
        ? $past(pkt_src_match) && $past(pkt_dst_match)
        : $past(pkt_src_match) || $past(pkt_dst_match))) else $error("mirror wrong");
    AST_VID: assert property ($past(vid_valid) |-> vid_out_q ==
        (($past(smii_cfg_q.null_vid_en) && $past(vid_in) == 12'h000) ? $past(port_vid)
        : $past(vid_in))) else $error("vid wrong");
    AST_RD_IDLE: assert property (!$past(rb_req.rd) |-> rd_data_q == 8'h00)
        else $error("read data outside slot");
    AST_PORT_RD: assert property ($past(rb_req.rd) && $past(rb_req.addr) == `SGC_ADDR_PORT
        |-> rd_data_q == {$past(smii_cfg_q), 3'h0}) else $error("port read wrong");
    AST_PRIO_RD: assert property ($past(rb_req.rd) && $past(rb_req.addr) == `SGC_ADDR_PRIO
        |-> rd_data_q == $past(prio_q)) else $error("prio read wrong");
    AST_GRANT_SRC: assert property (egr_take_hi_q |-> $past(egr_slot) && $past(egr_hi_pend))
        else $error("grant without slot");
    AST_ONE_GRANT: assert property (!(egr_take_hi_q && egr_take_lo_q))
        else $error("two grants");
    AST_STRICT: assert property ($past(prio_q[3:2]) == 2'h0 && $past(egr_slot)
        && $past(egr_hi_pend) |-> egr_take_hi_q && !egr_take_lo_q) else $error("strict broken");
endmodule

bind sgc_global_ctrl sgc_global_ctrl_checker chk_i (.clk(clk), .rst(rst), .ce(ce),
    .rb_req(rb_req), .rd_data_q(rd_data_q), .smii_cfg_q(smii_cfg_q),
    .smii_congested(smii_congested), .smii_jam_q(smii_jam_q), .smii_pause_q(smii_pause_q),
    .pkt_valid(pkt_valid), .pkt_src_match(pkt_src_match), .pkt_dst_match(pkt_dst_match),
    .mirror_q(mirror_q), .vid_valid(vid_valid), .vid_in(vid_in), .port_vid(port_vid),
    .vid_out_q(vid_out_q), .egr_slot(egr_slot), .egr_hi_pend(egr_hi_pend),
    .egr_take_hi_q(egr_take_hi_q), .egr_take_lo_q(egr_take_lo_q));

// >>> sim/sgc_mac_model.sv
// far-side mac model: backlogged egress queues and congestion source
`timescale 1ns/1ns

module sgc_mac_model
(
    input  wire logic hi_en,
    input  wire logic lo_en,
    input  wire logic cong_en,
    output logic      hi_pend,
    output logic      lo_pend,
    output logic      congested
);
    // queues never drain while enabled, so every slot sees demand
    assign hi_pend   = hi_en;
    assign lo_pend   = lo_en;
    assign congested = cong_en;
endmodule

// >>> sim/tb_top.sv
// self-checking bench of the switch global control block
`timescale 1ns/1ns
`include "sgc_map.svh"

module tb_top;
    logic                   clk, rst, hi_en, lo_en, cong_en, congested, jam, pause;
    logic                   pkt_valid, src, dst, mir_v, mir, vid_valid, vid_v, slot;
    logic                   hi_pend, lo_pend, take_hi, take_lo, backoff;
    logic [3:0]             strap;
    logic [7:0]             rd_data, rv;
    logic [11:0]            vid_in, vid_out;
    sgc_pkg::sgc_rb_req_s   rb_req;
    sgc_pkg::sgc_smii_cfg_s cfg;
    int                     mismatches, n_tests;

    sgc_global_ctrl dut (.clk(clk), .rst(rst), .ce(1'b1), .rb_req(rb_req), .rd_data_q(rd_data),
        .backoff_strap_pin(strap[3]), .duplex_strap_pin(strap[2]),
        .flow_ctrl_strap_pin(strap[1]), .speed_strap_pin(strap[0]),
        .backoff_aggr_q(backoff), .smii_cfg_q(cfg), .smii_congested(congested),
        .smii_jam_q(jam), .smii_pause_q(pause), .pkt_valid(pkt_valid), .pkt_src_match(src),
        .pkt_dst_match(dst), .mirror_valid_q(mir_v), .mirror_q(mir), .vid_valid(vid_valid),
        .vid_in(vid_in), .port_vid(12'hABC), .vid_valid_q(vid_v), .vid_out_q(vid_out),
        .egr_slot(slot), .egr_hi_pend(hi_pend), .egr_lo_pend(lo_pend),
        .egr_take_hi_q(take_hi), .egr_take_lo_q(take_lo));
    sgc_mac_model mac (.hi_en(hi_en), .lo_en(lo_en), .cong_en(cong_en),
        .hi_pend(hi_pend), .lo_pend(lo_pend), .congested(congested));

    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        rb_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        rb_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rb_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        rb_req <= '0;
        #1 d = rd_data;
    endtask

    task automatic do_reset(input logic [3:0] pins);
        @(posedge clk);
        strap <= pins;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic t_straps();
        chk({backoff, cfg}, {1'b1, 5'b01010});
        wr(`SGC_ADDR_PORT, 8'h00);
        #1 chk(cfg, 5'h00);
        do_reset(4'h0);
        chk({backoff, cfg}, 6'h00);
        rd(`SGC_ADDR_PRIO, rv);
        chk(rv, 8'h00);
        rd(`SGC_ADDR_STATUS, rv);
        chk(rv, 8'h80);
        $display("t_straps done");
    endtask

    task automatic t_regs();
        wr(`SGC_ADDR_PRIO, 8'hF5);
        wr(8'h20, 8'hFF);
        rd(`SGC_ADDR_PRIO, rv);
        chk(rv, 8'hF5);
        rd(8'h20, rv);
        chk(rv, 8'h00);
        wr(`SGC_ADDR_PORT, 8'h10);
        #1 chk(cfg, 5'b00010);
        wr(`SGC_ADDR_PORT, 8'hFF);
        rd(`SGC_ADDR_PORT, rv);
        chk(rv, 8'hF8);
        wr(`SGC_ADDR_CTRL1, 8'hFF);
        #1 chk(backoff, 1'b1);
        $display("t_regs done");
    endtask

    task automatic t_duplex();
        cong_en <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            wr(`SGC_ADDR_PORT, {i[2:0], 5'h00});
            @(posedge clk);
            #1 chk({jam, pause}, {i[2] & i[1], i[0] & ~i[1]});
        end
        cong_en <= 1'b0;
        $display("t_duplex done");
    endtask

    task automatic t_sniff_vid();
        for (int m = 0; m < 2; m++)
        begin
            wr(`SGC_ADDR_PRIO, {7'h00, m[0]});
            wr(`SGC_ADDR_PORT, {4'h0, m[0], 3'h0});
            for (int c = 0; c < 4; c++)
            begin
                @(posedge clk);
                pkt_valid <= 1'b1;
                src <= c[1];
                dst <= c[0];
                vid_valid <= 1'b1;
                vid_in <= c[0] ? 12'h123 : 12'h000;
                @(posedge clk);
                pkt_valid <= 1'b0;
                vid_valid <= 1'b0;
                #1 chk({mir_v, mir}, {1'b1, m[0] ? c == 3 : c != 0});
                chk({vid_v, vid_out}, {1'b1, c[0] ? 12'h123 : m[0] ? 12'hABC : 12'h000});
            end
        end
        $display("t_sniff_vid done");
    endtask

    task automatic t_sched();
        int n;
        int ratio [4];
        ratio = '{40, 10, 5, 2};
        for (int s = 0; s < 4; s++)
        begin
            wr(`SGC_ADDR_PRIO, {4'h0, s[1:0], 2'h0});
            slot <= 1'b1;
            hi_en <= 1'b1;
            lo_en <= 1'b1;
            n = 0;
            // look after the edge, so the grant launched there is seen
            repeat (40)
            begin
                @(posedge clk);
                #1;
                if (take_lo === 1'b1)
                    break;
            end
            for (int k = 0; k < 40; k++)
            begin
                @(posedge clk);
                #1 if (take_lo === 1'b1) break;
                if (take_hi === 1'b1) n++;
            end
            chk(n, ratio[s]);
            hi_en <= 1'b0;
            repeat (2) @(posedge clk);
            #1 chk({take_hi, take_lo}, 2'b01);
            lo_en <= 1'b0;
            slot <= 1'b0;
            repeat (2) @(posedge clk);
            #1 chk({take_hi, take_lo}, 2'b00);
        end
        $display("t_sched done");
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #(40 * 6000);
        mismatches++;
        stop_test();
    end

    initial
    begin
        {rst, hi_en, lo_en, cong_en, pkt_valid, src, dst, vid_valid, slot} = 9'h100;
        rb_req = '0;
        vid_in = 12'h000;
        strap = 4'hD;
        mismatches = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_straps();
        t_regs();
        t_duplex();
        t_sniff_vid();
        t_sched();
        stop_test();
    end
endmodule
